// ---- hw/gl_pkg.sv ----
package gl_pkg;
  // Graphics RAM geometry: 16 words per raster row, 128 rows
  localparam int GL_DATA_W = 16;
  localparam int GL_COL_W = 4;
  localparam int GL_ROW_W = 7;
  localparam int GL_PTR_W = GL_ROW_W + GL_COL_W;
  localparam int GL_WORDS = 2048;
  localparam logic [GL_COL_W-1:0] GL_COL_LAST = 4'hF;
  localparam logic [GL_COL_W-1:0] GL_COL_FIRST = 4'h0;
  localparam logic [GL_ROW_W-1:0] GL_ROW_LAST = 7'h7F;
  localparam logic [GL_ROW_W-1:0] GL_ROW_FIRST = 7'h00;
  localparam logic [GL_PTR_W-1:0] GL_PTR_ROW_STEP = 11'h010;

  // Register port
  localparam int GL_ADDR_W = 4;
  localparam logic [GL_ADDR_W-1:0] GL_REG_ENTRY = 4'h0;
  localparam logic [GL_ADDR_W-1:0] GL_REG_PROTECT = 4'h1;
  localparam logic [GL_ADDR_W-1:0] GL_REG_POINTER = 4'h2;
  localparam logic [GL_ADDR_W-1:0] GL_REG_WDATA = 4'h3;
  localparam logic [GL_ADDR_W-1:0] GL_REG_LATCH = 4'h4;
  localparam logic [GL_ADDR_W-1:0] GL_REG_STATUS = 4'h5;
  localparam logic [GL_ADDR_W-1:0] GL_REG_RDATA = 4'h6;

  // Entry register field positions
  localparam int GL_ENT_SCAN_LSB = 0;
  localparam int GL_ENT_UP_BIT = 2;
  localparam int GL_ENT_OP_LSB = 4;
  localparam int GL_ENT_ROT_LSB = 8;

  // Reset values
  localparam logic [GL_DATA_W-1:0] GL_PROTECT_RST = 16'h0000;
  localparam logic [GL_PTR_W-1:0] GL_PTR_RST = 11'h000;
  localparam logic [GL_DATA_W-1:0] GL_WORD_ZERO = 16'h0000;

  // Scan patterns
  typedef enum logic [1:0] {
    GL_SCAN_HORIZ = 2'b00,
    GL_SCAN_VERT = 2'b01,
    GL_SCAN_TWO_WORD = 2'b10,
    GL_SCAN_HOLD = 2'b11
  } gl_scan_t;

  // Combining functions
  typedef enum logic [1:0] {
    GL_OP_REPLACE = 2'b00,
    GL_OP_OR = 2'b01,
    GL_OP_AND = 2'b10,
    GL_OP_XOR = 2'b11
  } gl_op_t;

  // Entry mode settings as one carrier
  typedef struct packed {
    logic [2:0] bit_rotate_amount;
    gl_op_t logic_op_sel;
    logic step_up;
    gl_scan_t scan_direction_sel;
  } gl_entry_t;

  localparam gl_entry_t GL_ENTRY_RST = '{3'h0, GL_OP_REPLACE, 1'b1, GL_SCAN_HORIZ};
endpackage : gl_pkg

// ---- hw/gl_rmw_alu.sv ----
module gl_rmw_alu
  import gl_pkg::*;
(
  input wire logic [GL_DATA_W-1:0] i_orig,
  input wire logic [GL_DATA_W-1:0] i_host,
  input wire logic [2:0] i_rotate,
  input wire gl_op_t i_op,
  input wire logic [GL_DATA_W-1:0] i_protect,
  output logic [GL_DATA_W-1:0] o_result
);
  // Rotated host word and combined word before protection
  logic [GL_DATA_W-1:0] rotated;
  logic [GL_DATA_W-1:0] combined;

  // Rotate right; a doubled word keeps the shift lossless
  always_comb begin
    rotated = 16'(({i_host, i_host}) >> i_rotate);
  end

  // One function per code; plain replace when no op selected
  always_comb begin
    case (i_op)
      GL_OP_OR: combined = i_orig | rotated;
      GL_OP_AND: combined = i_orig & rotated;
      GL_OP_XOR: combined = i_orig ^ rotated;
      default: combined = rotated;
    endcase
  end

  // Protected bits keep the stored value
  always_comb begin
    o_result = (combined & ~i_protect) | (i_orig & i_protect);
  end
endmodule : gl_rmw_alu

// ---- hw/gl_write_engine.sv ----
// Behaviour
// - Logic codes read, combine, store same address
// - Original word held in read latch
// - Rotation and protect mask always applied
// - Horizontal scan steps pointer by one
// - Horizontal edge wraps to next row
// - Vertical scan adds sixteen per write
// - Vertical bottom wraps to next column top
// - Two-word mode alternates mask and complement
// - Two-word odd write steps one word
// - Two-word even write steps back, down row
// - Two-word bottom wraps to top row
//
// Chosen here: the strobed register port and the register offsets.
module gl_write_engine
  import gl_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [GL_ADDR_W-1:0] i_addr,
  input wire logic [GL_DATA_W-1:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [GL_DATA_W-1:0] o_rd_data
);
  // Graphics RAM storage, one word per 16 dots
  logic [GL_DATA_W-1:0] graphics_ram [GL_WORDS];
  // Entry mode settings
  gl_entry_t entry;
  // Bits set here are protected from rewrite
  logic [GL_DATA_W-1:0] write_bit_protect;
  // Word pointer, row in the high bits
  logic [GL_PTR_W-1:0] gram_pointer;
  logic [GL_PTR_W-1:0] next_gram_pointer;
  // Original word from the last engine write
  logic [GL_DATA_W-1:0] read_latch;
  // High when the coming write is an even one
  logic even_write;
  // Decoded strobes
  logic data_write;
  // Current stored word and the word to write back
  logic [GL_DATA_W-1:0] orig_word;
  logic [GL_DATA_W-1:0] result_word;
  // Effective protect mask for this write
  logic [GL_DATA_W-1:0] eff_protect;
  // Pointer split into row and column
  logic [GL_ROW_W-1:0] row;
  logic [GL_COL_W-1:0] col;

  assign data_write = i_wr && (i_addr == GL_REG_WDATA);
  assign row = gram_pointer[GL_PTR_W-1:GL_COL_W];
  assign col = gram_pointer[GL_COL_W-1:0];
  // Read happens combinationally so the whole update fits one cycle
  assign orig_word = graphics_ram[gram_pointer];

  // Two-word mode uses the complement on even writes
  always_comb begin
    if ((entry.scan_direction_sel == GL_SCAN_TWO_WORD) && even_write) begin
      eff_protect = ~write_bit_protect;
    end else begin
      eff_protect = write_bit_protect;
    end
  end

  // Rotate, combine and protect
  gl_rmw_alu u_alu (
    .i_orig(orig_word),
    .i_host(i_wr_data),
    .i_rotate(entry.bit_rotate_amount),
    .i_op(entry.logic_op_sel),
    .i_protect(eff_protect),
    .o_result(result_word)
  );

  // Pointer step for each scan pattern
  always_comb begin
    next_gram_pointer = gram_pointer;
    case (entry.scan_direction_sel)
      GL_SCAN_HORIZ: begin
        if (entry.step_up) begin
          // Carry out of the column lands on the next row's left edge
          next_gram_pointer = gram_pointer + 11'h001;
        end else if (col == GL_COL_FIRST) begin
          // Left edge goes to the right edge one row below
          next_gram_pointer = {row + 7'h01, GL_COL_LAST};
        end else begin
          next_gram_pointer = gram_pointer - 11'h001;
        end
      end
      GL_SCAN_VERT: begin
        if (row == GL_ROW_LAST) begin
          // Bottom goes to the top of the neighbouring column
          if (entry.step_up) begin
            next_gram_pointer = {GL_ROW_FIRST, col + 4'h1};
          end else begin
            next_gram_pointer = {GL_ROW_FIRST, col - 4'h1};
          end
        end else begin
          next_gram_pointer = gram_pointer + GL_PTR_ROW_STEP;
        end
      end
      GL_SCAN_TWO_WORD: begin
        if (!even_write) begin
          // Column stays inside the row so the pair never splits rows
          if (entry.step_up) begin
            next_gram_pointer = {row, col + 4'h1};
          end else begin
            next_gram_pointer = {row, col - 4'h1};
          end
        end else if (entry.step_up) begin
          // Row counter wraps from the bottom to the top row
          next_gram_pointer = {row + 7'h01, col - 4'h1};
        end else begin
          next_gram_pointer = {row + 7'h01, col + 4'h1};
        end
      end
      default: begin
        // Reserved pattern leaves the pointer alone
        next_gram_pointer = gram_pointer;
      end
    endcase
  end

  // Write-back into the same address in the strobe cycle
  always_ff @(posedge i_clock) begin
    if (data_write) begin
      graphics_ram[gram_pointer] <= result_word;
    end
  end

  // Original word kept for the host to read back at the latch register
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      read_latch <= GL_WORD_ZERO;
    end else if (data_write) begin
      read_latch <= orig_word;
    end
  end

  // Pointer: loaded by software, stepped after each write
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gram_pointer <= GL_PTR_RST;
    end else if (i_wr && (i_addr == GL_REG_POINTER)) begin
      gram_pointer <= i_wr_data[GL_PTR_W-1:0];
    end else if (data_write) begin
      gram_pointer <= next_gram_pointer;
    end
  end

  // Odd/even tracking; pointer or mode load restarts at odd
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      even_write <= 1'b0;
    end else if (i_wr && ((i_addr == GL_REG_POINTER) || (i_addr == GL_REG_ENTRY))) begin
      even_write <= 1'b0;
    end else if (data_write && (entry.scan_direction_sel == GL_SCAN_TWO_WORD)) begin
      even_write <= ~even_write;
    end
  end

  // Entry mode register
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      entry <= GL_ENTRY_RST;
    end else if (i_wr && (i_addr == GL_REG_ENTRY)) begin
      entry.scan_direction_sel <= gl_scan_t'(i_wr_data[GL_ENT_SCAN_LSB +: 2]);
      entry.step_up <= i_wr_data[GL_ENT_UP_BIT];
      entry.logic_op_sel <= gl_op_t'(i_wr_data[GL_ENT_OP_LSB +: 2]);
      entry.bit_rotate_amount <= i_wr_data[GL_ENT_ROT_LSB +: 3];
    end
  end

  // Protect mask register
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      write_bit_protect <= GL_PROTECT_RST;
    end else if (i_wr && (i_addr == GL_REG_PROTECT)) begin
      write_bit_protect <= i_wr_data;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_data <= GL_WORD_ZERO;
    end else if (i_rd) begin
      case (i_addr)
        GL_REG_ENTRY: begin
          o_rd_data <= {5'h00, entry.bit_rotate_amount, 2'h0, entry.logic_op_sel, 1'b0,
                        entry.step_up, entry.scan_direction_sel};
        end
        GL_REG_PROTECT: o_rd_data <= write_bit_protect;
        GL_REG_POINTER: o_rd_data <= {5'h00, gram_pointer};
        GL_REG_LATCH: o_rd_data <= read_latch;
        GL_REG_STATUS: o_rd_data <= {15'h0000, even_write};
        GL_REG_RDATA: o_rd_data <= orig_word;
        // Write-only and unmapped addresses read zero
        default: o_rd_data <= GL_WORD_ZERO;
      endcase
    end else begin
      o_rd_data <= GL_WORD_ZERO;
    end
  end

  // Checks
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);
  // The array is not reset, so the first fill fetches unknown words into the
  // latch; its check uses case equality so those words compare as they are

  store_result_a: assert property (data_write |=>
    graphics_ram[$past(gram_pointer)] == $past(result_word))
    else $error("write-back word wrong");

  latch_capture_a: assert property (data_write |=> read_latch === $past(orig_word))
    else $error("read latch missed original");

  // The fetched word never reaches the host outside a register read
  latch_hidden_a: assert property (data_write |=> o_rd_data == GL_WORD_ZERO)
    else $error("fetched word leaked to host");

  rd_idle_a: assert property (!i_rd |=> o_rd_data == GL_WORD_ZERO)
    else $error("read data outside read cycle");

  protect_keep_a: assert property (data_write |->
    ((result_word ^ orig_word) & eff_protect) == GL_WORD_ZERO)
    else $error("protected bit changed");

  // Pointer load and steps for the horizontal and vertical scans
  horiz_step_a: assert property (data_write && entry.scan_direction_sel == GL_SCAN_HORIZ
    && col != GL_COL_FIRST && col != GL_COL_LAST |=>
    gram_pointer == ($past(entry.step_up) ? $past(gram_pointer) + 11'h001
                                          : $past(gram_pointer) - 11'h001))
    else $error("horizontal step wrong");

  horiz_edge_a: assert property (data_write && entry.scan_direction_sel == GL_SCAN_HORIZ
    && !entry.step_up && col == GL_COL_FIRST |=>
    col == GL_COL_LAST && row == $past(row) + 7'h01)
    else $error("left edge wrap wrong");

  horiz_wrap_a: assert property (data_write && entry.scan_direction_sel == GL_SCAN_HORIZ
    && entry.step_up && col == GL_COL_LAST |=>
    col == GL_COL_FIRST && row == $past(row) + 7'h01)
    else $error("right edge wrap wrong");

  horiz_dec_a: assert property (data_write && entry.scan_direction_sel == GL_SCAN_HORIZ
    && !entry.step_up && col == GL_COL_LAST |=>
    gram_pointer == $past(gram_pointer) - 11'h001)
    else $error("step down from right edge wrong");

  ptr_load_a: assert property (i_wr && i_addr == GL_REG_POINTER |=>
    gram_pointer == $past(i_wr_data[GL_PTR_W-1:0]))
    else $error("pointer load wrong");

  vert_step_a: assert property (data_write && entry.scan_direction_sel == GL_SCAN_VERT
    && row != GL_ROW_LAST |=> gram_pointer == $past(gram_pointer) + GL_PTR_ROW_STEP)
    else $error("vertical step wrong");

  vert_wrap_a: assert property (data_write && entry.scan_direction_sel == GL_SCAN_VERT
    && row == GL_ROW_LAST && entry.step_up |=> row == GL_ROW_FIRST && col == $past(col) + 4'h1)
    else $error("vertical wrap wrong");

  vert_left_a: assert property (data_write && entry.scan_direction_sel == GL_SCAN_VERT
    && row == GL_ROW_LAST && !entry.step_up |=>
    row == GL_ROW_FIRST && col == $past(col) - 4'h1)
    else $error("vertical left wrap wrong");

  // Two-word mode: mask phase, paired steps and the bottom wrap
  mask_flip_a: assert property (data_write
    && entry.scan_direction_sel == GL_SCAN_TWO_WORD |->
    (((result_word ^ orig_word) & (even_write ? ~write_bit_protect : write_bit_protect))
    == GL_WORD_ZERO) ##1 even_write != $past(even_write))
    else $error("two-word mask phase wrong");

  phase_keep_a: assert property (data_write
    && entry.scan_direction_sel != GL_SCAN_TWO_WORD |=> even_write == $past(even_write))
    else $error("phase moved outside two-word mode");

  phase_restart_a: assert property (i_wr && (i_addr == GL_REG_POINTER
    || i_addr == GL_REG_ENTRY) |=> !even_write)
    else $error("phase not restarted at odd");

  odd_step_a: assert property (data_write && !even_write && entry.step_up
    && entry.scan_direction_sel == GL_SCAN_TWO_WORD |=>
    row == $past(row) && col == $past(col) + 4'h1)
    else $error("odd step wrong");

  odd_down_a: assert property (data_write && !even_write && !entry.step_up
    && entry.scan_direction_sel == GL_SCAN_TWO_WORD |=>
    row == $past(row) && col == $past(col) - 4'h1)
    else $error("odd step down wrong");

  even_step_a: assert property (data_write && even_write && !entry.step_up
    && entry.scan_direction_sel == GL_SCAN_TWO_WORD |=>
    row == $past(row) + 7'h01 && col == $past(col) + 4'h1)
    else $error("even step wrong");

  even_up_a: assert property (data_write && even_write && entry.step_up
    && entry.scan_direction_sel == GL_SCAN_TWO_WORD |=>
    row == $past(row) + 7'h01 && col == $past(col) - 4'h1)
    else $error("even step up wrong");

  two_wrap_a: assert property (data_write && even_write && row == GL_ROW_LAST
    && entry.scan_direction_sel == GL_SCAN_TWO_WORD |=> row == GL_ROW_FIRST)
    else $error("two-word wrap wrong");

  // Functions are checked unrotated, rotation alone under plain replace;
  // protected bits are left out here since protect_keep_a covers them
  or_func_a: assert property (data_write && entry.logic_op_sel == GL_OP_OR
    && entry.bit_rotate_amount == 3'h0 |->
    ((result_word ^ (orig_word | i_wr_data)) & ~eff_protect) == GL_WORD_ZERO)
    else $error("or function wrong");

  and_func_a: assert property (data_write && entry.logic_op_sel == GL_OP_AND
    && entry.bit_rotate_amount == 3'h0 |->
    ((result_word ^ (orig_word & i_wr_data)) & ~eff_protect) == GL_WORD_ZERO)
    else $error("and function wrong");

  xor_func_a: assert property (data_write && entry.logic_op_sel == GL_OP_XOR
    && entry.bit_rotate_amount == 3'h0 |->
    ((result_word ^ (orig_word ^ i_wr_data)) & ~eff_protect) == GL_WORD_ZERO)
    else $error("xor function wrong");

  rot_one_a: assert property (data_write && entry.logic_op_sel == GL_OP_REPLACE
    && entry.bit_rotate_amount == 3'h1 |->
    ((result_word ^ {i_wr_data[0], i_wr_data[15:1]}) & ~eff_protect) == GL_WORD_ZERO)
    else $error("rotate by one wrong");

  rot_seven_a: assert property (data_write && entry.logic_op_sel == GL_OP_REPLACE
    && entry.bit_rotate_amount == 3'h7 |->
    ((result_word ^ {i_wr_data[6:0], i_wr_data[15:7]}) & ~eff_protect) == GL_WORD_ZERO)
    else $error("rotate by seven wrong");

  rmw_horiz_c: cover property (data_write && entry.logic_op_sel != GL_OP_REPLACE
    && entry.scan_direction_sel == GL_SCAN_HORIZ);
  vert_wrap_c: cover property (data_write && entry.scan_direction_sel == GL_SCAN_VERT
    && row == GL_ROW_LAST);
  // Host write strobes arrive every other cycle at the fastest
  two_word_pair_c: cover property (data_write && entry.scan_direction_sel == GL_SCAN_TWO_WORD
    ##2 data_write && even_write);
  vert_left_c: cover property (data_write && entry.scan_direction_sel == GL_SCAN_VERT
    && row == GL_ROW_LAST && !entry.step_up);
  rotate_rmw_c: cover property (data_write && entry.logic_op_sel != GL_OP_REPLACE
    && entry.bit_rotate_amount != 3'h0);
endmodule : gl_write_engine

// ---- testbench/gl_host_model.sv ----
// Host side of the register port: one-cycle strobes, no waits
module gl_host_model
  import gl_pkg::*;
(
  input wire logic i_clock,
  output logic [GL_ADDR_W-1:0] o_addr,
  output logic [GL_DATA_W-1:0] o_wr_data,
  output logic o_wr,
  output logic o_rd,
  input wire logic [GL_DATA_W-1:0] i_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;

  // Bus idle at time zero
  initial begin
    o_addr = '0;
    o_wr_data = '0;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // Write: strobe for one edge, then scramble the released lines
  task automatic wr(input logic [GL_ADDR_W-1:0] a, input logic [GL_DATA_W-1:0] d);
    @(posedge i_clock);
    o_addr <= a;
    o_wr_data <= d;
    o_wr <= 1'b1;
    @(posedge i_clock);
    o_wr <= 1'b0;
    // Stale address or data must never be relied on
    o_addr <= ~a;
    o_wr_data <= ~d;
  endtask : wr

  // Read: data stands only in the cycle after the strobe edge
  task automatic rd(input logic [GL_ADDR_W-1:0] a, output logic [GL_DATA_W-1:0] d);
    @(posedge i_clock);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clock);
    o_rd <= 1'b0;
    o_addr <= ~a;
    // Sample mid-cycle, away from the registered output's edge
    @(negedge i_clock);
    d = i_rd_data;
  endtask : rd
endmodule : gl_host_model

// ---- testbench/gl_write_engine_tb_top.sv ----
// Bench: integer model of the engine compared at every read
module gl_write_engine_tb_top
  import gl_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock = 1'b0;
  logic rst_b = 1'b0; // Active low, held at start
  logic [GL_ADDR_W-1:0] addr;
  logic [GL_DATA_W-1:0] wr_data;
  logic [GL_DATA_W-1:0] rd_data;
  logic wr;
  logic rd;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int mem[GL_WORDS]; // Model of the graphics RAM
  int ptr, ent, prot, latch, even; // Model registers
  int edge_ptr[4] = '{0, 15, 2032, 2047}; // Corners of the array
  logic [31:0] seed = 32'hB194;

  // 10 MHz clock
  always #50 clock = ~clock;

  gl_write_engine dut (.i_clock(clock), .i_rst_b(rst_b), .i_addr(addr), .i_wr_data(wr_data),
    .i_wr(wr), .i_rd(rd), .o_rd_data(rd_data));
  gl_host_model host (.i_clock(clock), .o_addr(addr), .o_wr_data(wr_data), .o_wr(wr),
    .o_rd(rd), .i_rd_data(rd_data));

  // Hang guard, nearly three times the expected run
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      errors = errors + 1;
      end_sim();
    end
  end

  // Xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [3:0] a, input int exp, input string what);
    logic [15:0] v;
    host.rd(a, v);
    chk(v, 16'(exp), what);
  endtask : rd_chk

  // Bus write plus the model's reaction to it
  task automatic wr_reg(input logic [3:0] a, input int d);
    int orig, r, comb, p, row, col, up, sc;
    host.wr(a, d[15:0]);
    sc = ent & 3;
    up = (ent >> 2) & 1;
    row = ptr >> 4;
    col = ptr & 15;
    case (a)
      GL_REG_ENTRY: begin
        ent = d;
        even = 0; // Phase restarts at odd
      end
      GL_REG_PROTECT: prot = d;
      GL_REG_POINTER: begin
        ptr = d & 2047;
        even = 0;
      end
      GL_REG_WDATA: begin
        r = (ent >> 8) & 7;
        r = ((d >> r) | (d << (16 - r))) & 16'hFFFF;
        orig = mem[ptr];
        case ((ent >> 4) & 3)
          0: comb = r;
          1: comb = orig | r;
          2: comb = orig & r;
          default: comb = orig ^ r;
        endcase
        p = (sc == 2 && even != 0) ? ~prot : prot;
        mem[ptr] = ((comb & ~p) | (orig & p)) & 16'hFFFF;
        latch = orig;
        case (sc)
          0: ptr = up ? (ptr + 1) & 2047 : (col == 0 ? (((row + 1) & 127) << 4) | 15 : ptr - 1);
          1: ptr = (row != 127) ? ptr + 16 : ((col + (up ? 1 : -1)) & 15);
          2: ptr = even ? (((row + 1) & 127) << 4) | ((col + (up ? -1 : 1)) & 15)
            : (row << 4) | ((col + (up ? 1 : -1)) & 15);
          default: ; // Pointer held
        endcase
        if (sc == 2) even = !even;
      end
      default: ; // Read-only and unmapped places ignore writes
    endcase
  endtask : wr_reg

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // Main sequence
  initial begin
    int k, n;
    ent = 4;
    prot = 0;
    ptr = 0;
    latch = 0;
    even = 0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    // Reset values, write-only data port and an unmapped place all read as listed
    for (k = 0; k < 6; k++) rd_chk(k[3:0], k == 0 ? 4 : 0, "reset value");
    rd_chk(4'hF, 0, "unmapped");
    $display("test reset done");
    // Plain fill sweeps the whole array and wraps back to word zero
    for (k = 0; k < GL_WORDS; k++) wr_reg(GL_REG_WDATA, rnd() & 16'hFFFF);
    rd_chk(GL_REG_POINTER, ptr, "fill wrap");
    $display("test fill done");
    // Every scan, direction and code unrotated, then rotated, then random settings
    for (n = 0; n < 160; n++) begin
      wr_reg(GL_REG_ENTRY, n < 64 ? (n & 7) | ((n & 24) << 1)
        | ((n & 32) != 0 ? rnd() & 16'h0700 : 0) : rnd() & 16'h0737);
      wr_reg(GL_REG_PROTECT, rnd() & 16'hFFFF);
      wr_reg(GL_REG_POINTER, (n % 5 == 4) ? rnd() & 2047 : edge_ptr[n % 5]);
      repeat (4) begin
        wr_reg(GL_REG_WDATA, rnd() & 16'hFFFF);
        rd_chk(GL_REG_LATCH, latch, "latch");
        rd_chk(GL_REG_POINTER, ptr, "pointer");
        rd_chk(GL_REG_STATUS, even, "phase");
      end
    end
    $display("test modes done");
    // Writes to read-only and unmapped places leave them unchanged
    wr_reg(GL_REG_LATCH, 16'hFFFF);
    wr_reg(4'hC, 16'hFFFF);
    rd_chk(GL_REG_LATCH, latch, "latch kept");
    rd_chk(4'hC, 0, "unmapped");
    // Every stored word against the model
    for (k = 0; k < GL_WORDS; k++) begin
      wr_reg(GL_REG_POINTER, k);
      rd_chk(GL_REG_RDATA, mem[k], "word");
    end
    $display("test sweep done");
    end_sim();
  end
endmodule : gl_write_engine_tb_top
